/* flash_host_consts.svh */
// Offsets, command codes and timing counts for the parallel flash host
// Behaviour
// - Sector erase: six writes ending 30H at block
// - Whole erase: six writes ending 10H at 5555H
// - Doubtful status: reread twice, both must match
// - Full byte valid 1 us after completion
// - Program needs three unlocks, erase six
// - Address at later fall, data earlier rise
`ifndef FLASH_HOST_CONSTS_SVH
`define FLASH_HOST_CONSTS_SVH

// Command addresses and codes
`define ADR_UNLOCK1 19'h05555
`define ADR_UNLOCK2 19'h02AAA
`define ADR_ZERO 19'h00000
`define CODE_UNLOCK1 8'hAA
`define CODE_UNLOCK2 8'h55
`define CODE_PROGRAM 8'hA0
`define CODE_ERASE_SETUP 8'h80
`define CODE_SECTOR_ERASE 8'h30
`define CODE_WHOLE_ERASE 8'h10
`define CODE_ID_ENTRY 8'h90
`define CODE_ID_EXIT 8'hF0
`define ERASED_BYTE 8'hFF
// Low address bit of an erase block (4 KByte)
`define BLOCK_LSB 12
// Status bit positions
`define POLL_BIT 7
`define TOGGLE_BIT 6
// Sequence lengths
`define STEPS_PROGRAM 3'h4
`define STEPS_ERASE 3'h6
`define STEPS_ID_ENTRY 3'h3
`define STEPS_ID_EXIT 3'h1
`define RETRY_READS 2'h2

// Timing
`define CLK_NS 20
`define GLITCH_NS 5
`define RC_NS 70
`define SETTLE_US 1
`define PROG_MAX_US 20
// Least times round up, longest round down
`define GLITCH_CYC ((`GLITCH_NS + `CLK_NS - 1) / `CLK_NS)
`define WE_LOW_CYC (`GLITCH_CYC + 1)
`define RC_CYC ((`RC_NS + `CLK_NS - 1) / `CLK_NS)
`define SETTLE_CYC ((`SETTLE_US * 1000 + `CLK_NS - 1) / `CLK_NS)
`define PROG_MAX_CYC ((`PROG_MAX_US * 1000) / `CLK_NS)

`endif

/* flash_host_pkg.sv */
// Types shared by the flash host modules
package flash_host_pkg;

	// User operations
	typedef enum logic [2:0]
	{
		OP_READ = 3'h0,
		OP_PROGRAM = 3'h1,
		OP_SECTOR_ERASE = 3'h2,
		OP_WHOLE_ERASE = 3'h3,
		OP_ID_ENTRY = 3'h4,
		OP_ID_EXIT = 3'h5
	} op_t;

	// Bus cycle engine phases
	typedef enum logic [3:0]
	{
		PH_IDLE = 4'h1,
		PH_SETUP = 4'h2,
		PH_STROBE = 4'h4,
		PH_HOLD = 4'h8
	} phase_t;

	// Sequencer states
	typedef enum logic [7:0]
	{
		S_IDLE = 8'h01,
		S_WRITE = 8'h02,
		S_READ = 8'h04,
		S_POLL = 8'h08,
		S_SETTLE = 8'h10,
		S_VERIFY = 8'h20,
		S_ISSUE = 8'h40,
		S_RESPOND = 8'h80
	} state_t;

	// Bus cycle engine state
	typedef struct packed
	{
		phase_t ph;
		logic [7:0] cnt;
		logic wr;
		logic [18:0] addr;
		logic [7:0] dq_o;
		logic dq_oe_n;
		logic ce_n;
		logic oe_n;
		logic we_n;
		logic done;
		logic [7:0] rdata;
	} engine_t;

	// Sequencer state
	typedef struct packed
	{
		state_t st;
		state_t after;
		op_t op;
		logic [2:0] step;
		logic [18:0] addr;
		logic [7:0] data;
		logic [10:0] cnt;
		logic first;
		logic tog;
		logic [1:0] retry;
		logic req;
		logic wr;
		logic [18:0] caddr;
		logic [7:0] cdata;
		logic ready;
		logic rsp_valid;
		logic [7:0] rsp_data;
		logic rsp_err;
	} seq_t;

endpackage

/* flash_cycle_if.sv */
// Handshake between the sequencer and the bus cycle engine
`timescale 1ns/1ps
interface flash_cycle_if;
	logic req; // One-cycle start pulse
	logic wr; // High for a write cycle
	logic [18:0] addr; // Cycle address
	logic [7:0] wdata; // Write data
	logic done; // One-cycle end pulse
	logic [7:0] rdata; // Read data, valid with done

	modport master (output req, wr, addr, wdata, input done, rdata);
	modport engine (input req, wr, addr, wdata, output done, rdata);
endinterface

/* flash_bus_cycle.sv */
// One read or write cycle on the flash pins
`timescale 1ns/1ps
`include "flash_host_consts.svh"
module flash_bus_cycle
(
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Sequencer side
	flash_cycle_if.engine cyc,
	// Flash pins, all from flops
	output logic [18:0] addr,
	output logic [7:0] dq_o,
	output logic dq_oe_n,
	input wire logic [7:0] dq_i,
	output logic ce_n,
	output logic oe_n,
	output logic we_n
);
	flash_host_pkg::engine_t r_reg; // Registered state
	flash_host_pkg::engine_t r_next; // Next state

	// Phase walk: setup, strobe, hold, back to idle
	always_comb
	begin
		r_next = r_reg;
		r_next.done = 1'b0;
		case (r_reg.ph)
			flash_host_pkg::PH_IDLE:
			begin
				if (cyc.req)
				begin
					// Address settles with select low before any strobe falls
					r_next.ph = flash_host_pkg::PH_SETUP;
					r_next.wr = cyc.wr;
					r_next.addr = cyc.addr;
					r_next.dq_o = cyc.wdata;
					r_next.dq_oe_n = ~cyc.wr;
					r_next.ce_n = 1'b0;
				end
			end
			flash_host_pkg::PH_SETUP:
			begin
				r_next.ph = flash_host_pkg::PH_STROBE;
				if (r_reg.wr)
				begin
					// Output enable stays high so the write is not inhibited
					r_next.we_n = 1'b0;
					r_next.cnt = 8'(`WE_LOW_CYC - 1);
				end
				else
				begin
					r_next.oe_n = 1'b0;
					r_next.cnt = 8'(`RC_CYC - 1);
				end
			end
			flash_host_pkg::PH_STROBE:
			begin
				if (r_reg.cnt != 8'h00)
				begin
					r_next.cnt = r_reg.cnt - 8'h01;
				end
				else
				begin
					// Strobe rises first; data keeps driving through hold
					r_next.ph = flash_host_pkg::PH_HOLD;
					r_next.we_n = 1'b1;
					r_next.oe_n = 1'b1;
					if (!r_reg.wr)
					begin
						r_next.rdata = dq_i;
					end
				end
			end
			flash_host_pkg::PH_HOLD:
			begin
				// One idle cycle gives read recovery and data hold
				r_next.ph = flash_host_pkg::PH_IDLE;
				r_next.ce_n = 1'b1;
				r_next.dq_oe_n = 1'b1;
				r_next.done = 1'b1;
			end
			default:
			begin
				r_next.ph = flash_host_pkg::PH_IDLE;
			end
		endcase
	end

	// State register
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			r_reg <= '{ph: flash_host_pkg::PH_IDLE, cnt: 8'h00, wr: 1'b0, addr: 19'h00000,
				dq_o: 8'h00, dq_oe_n: 1'b1, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
				done: 1'b0, rdata: 8'h00};
		end
		else
		begin
			r_reg <= r_next;
		end
	end

	// Outputs straight from the register
	assign addr = r_reg.addr;
	assign dq_o = r_reg.dq_o;
	assign dq_oe_n = r_reg.dq_oe_n;
	assign ce_n = r_reg.ce_n;
	assign oe_n = r_reg.oe_n;
	assign we_n = r_reg.we_n;
	assign cyc.done = r_reg.done;
	assign cyc.rdata = r_reg.rdata;
endmodule

/* flash_host.sv */
// Command sequencer that drives a parallel flash through its pins
`timescale 1ns/1ps
`include "flash_host_consts.svh"
module flash_host
(
	// Clock and reset
	input wire logic CLK,
	input wire logic SRST,
	// Command port
	input wire logic CMD_VALID,
	input wire logic [2:0] CMD_OP,
	input wire logic [18:0] CMD_ADDR,
	input wire logic [7:0] CMD_DATA,
	output logic CMD_READY,
	// Answer port
	output logic RSP_VALID,
	output logic [7:0] RSP_DATA,
	output logic RSP_ERR,
	// Flash pins
	output logic [18:0] F_ADDR,
	output logic [7:0] F_DQ_O,
	output logic F_DQ_OE_N,
	input wire logic [7:0] F_DQ_I,
	output logic F_CE_N,
	output logic F_OE_N,
	output logic F_WE_N
);
	flash_cycle_if cyc(); // Link to the cycle engine
	flash_host_pkg::seq_t r_reg; // Registered state
	flash_host_pkg::seq_t r_next; // Next state
	logic [26:0] step_word; // Address and data of the current write
	logic [2:0] step_count; // Writes in the current sequence
	logic [7:0] expect_byte; // Value the array must hold when done

	////////////////////////////////////////////////////////////////////////
	// Command tables

	// Address and data of each write of a sequence
	always_comb
	begin
		step_word = {`ADR_ZERO, `CODE_ID_EXIT};
		if (r_reg.step == 3'h0 && r_reg.op != flash_host_pkg::OP_ID_EXIT)
		begin
			step_word = {`ADR_UNLOCK1, `CODE_UNLOCK1};
		end
		else if (r_reg.step == 3'h1 || r_reg.step == 3'h4)
		begin
			step_word = {`ADR_UNLOCK2, `CODE_UNLOCK2};
		end
		else if (r_reg.step == 3'h3)
		begin
			// Program data write, or second unlock of an erase
			if (r_reg.op == flash_host_pkg::OP_PROGRAM)
			begin
				step_word = {r_reg.addr, r_reg.data};
			end
			else
			begin
				step_word = {`ADR_UNLOCK1, `CODE_UNLOCK1};
			end
		end
		else if (r_reg.step == 3'h2)
		begin
			case (r_reg.op)
				flash_host_pkg::OP_PROGRAM: step_word = {`ADR_UNLOCK1, `CODE_PROGRAM};
				flash_host_pkg::OP_ID_ENTRY: step_word = {`ADR_UNLOCK1, `CODE_ID_ENTRY};
				default: step_word = {`ADR_UNLOCK1, `CODE_ERASE_SETUP};
			endcase
		end
		else if (r_reg.step == 3'h5)
		begin
			// Final erase write: block base or the whole-array code
			if (r_reg.op == flash_host_pkg::OP_SECTOR_ERASE)
			begin
				step_word = {r_reg.addr[18:`BLOCK_LSB], `BLOCK_LSB'(0),
					`CODE_SECTOR_ERASE};
			end
			else
			begin
				step_word = {`ADR_UNLOCK1, `CODE_WHOLE_ERASE};
			end
		end
	end

	// Sequence length and expected result per operation
	always_comb
	begin
		case (r_reg.op)
			flash_host_pkg::OP_PROGRAM: step_count = `STEPS_PROGRAM;
			flash_host_pkg::OP_ID_ENTRY: step_count = `STEPS_ID_ENTRY;
			flash_host_pkg::OP_ID_EXIT: step_count = `STEPS_ID_EXIT;
			default: step_count = `STEPS_ERASE;
		endcase
		// Erase leaves every bit at one
		expect_byte = (r_reg.op == flash_host_pkg::OP_PROGRAM) ? r_reg.data
			: `ERASED_BYTE;
	end

	////////////////////////////////////////////////////////////////////////
	// Sequencer

	// Next state; the cycle request is a one-cycle pulse
	always_comb
	begin
		r_next = r_reg;
		r_next.req = 1'b0;
		r_next.rsp_valid = 1'b0;
		case (r_reg.st)
			flash_host_pkg::S_IDLE:
			begin
				if (CMD_VALID)
				begin
					r_next.op = flash_host_pkg::op_t'(CMD_OP);
					r_next.addr = CMD_ADDR;
					r_next.data = CMD_DATA;
					r_next.step = 3'h0;
					r_next.ready = 1'b0;
					r_next.rsp_err = 1'b0;
					if (CMD_OP == flash_host_pkg::OP_READ)
					begin
						// Plain read; in identification mode 0 and 1 give the codes
						r_next.req = 1'b1;
						r_next.wr = 1'b0;
						r_next.caddr = CMD_ADDR;
						r_next.st = flash_host_pkg::S_READ;
					end
					else
					begin
						r_next.st = flash_host_pkg::S_ISSUE;
					end
				end
			end
			flash_host_pkg::S_ISSUE:
			begin
				// Launch the current write of the sequence
				r_next.req = 1'b1;
				r_next.wr = 1'b1;
				r_next.caddr = step_word[26:8];
				r_next.cdata = step_word[7:0];
				r_next.st = flash_host_pkg::S_WRITE;
			end
			flash_host_pkg::S_WRITE:
			begin
				if (cyc.done)
				begin
					r_next.step = r_reg.step + 3'h1;
					if (r_reg.step + 3'h1 != step_count)
					begin
						r_next.st = flash_host_pkg::S_ISSUE;
					end
					else if (r_reg.op == flash_host_pkg::OP_ID_ENTRY
						|| r_reg.op == flash_host_pkg::OP_ID_EXIT)
					begin
						// Mode writes: wait one read cycle before answering
						r_next.cnt = 11'(`RC_CYC);
						r_next.after = flash_host_pkg::S_RESPOND;
						r_next.st = flash_host_pkg::S_SETTLE;
					end
					else
					begin
						// Last strobe has risen, so status is now valid
						r_next.first = 1'b1;
						r_next.cnt = 11'h000;
						r_next.req = 1'b1;
						r_next.wr = 1'b0;
						r_next.caddr = step_word[26:8];
						r_next.st = flash_host_pkg::S_POLL;
					end
				end
			end
			flash_host_pkg::S_POLL:
			begin
				// No new command is sent while the operation runs
				r_next.cnt = (r_reg.cnt == 11'h7FF) ? r_reg.cnt : r_reg.cnt + 11'h001;
				if (cyc.done)
				begin
					r_next.first = 1'b0;
					r_next.tog = cyc.rdata[`TOGGLE_BIT];
					// Done once bit 6 holds and bit 7 shows the final value
					if (!r_reg.first && cyc.rdata[`TOGGLE_BIT] == r_reg.tog
						&& cyc.rdata[`POLL_BIT] == expect_byte[`POLL_BIT])
					begin
						r_next.cnt = 11'(`SETTLE_CYC);
						r_next.retry = 2'h0;
						r_next.after = flash_host_pkg::S_VERIFY;
						r_next.st = flash_host_pkg::S_SETTLE;
					end
					else if (r_reg.op == flash_host_pkg::OP_PROGRAM
						&& r_reg.cnt >= 11'(`PROG_MAX_CYC))
					begin
						// Program overran its longest time
						r_next.rsp_err = 1'b1;
						r_next.st = flash_host_pkg::S_RESPOND;
					end
					else
					begin
						r_next.req = 1'b1;
					end
				end
			end
			flash_host_pkg::S_SETTLE:
			begin
				// Count out the wait, then read or answer
				if (r_reg.cnt > 11'h001)
				begin
					r_next.cnt = r_reg.cnt - 11'h001;
				end
				else
				begin
					r_next.st = r_reg.after;
					if (r_reg.after == flash_host_pkg::S_VERIFY)
					begin
						r_next.req = 1'b1;
					end
				end
			end
			flash_host_pkg::S_VERIFY:
			begin
				if (cyc.done)
				begin
					r_next.rsp_data = cyc.rdata;
					if (cyc.rdata != expect_byte && r_reg.retry == 2'h0)
					begin
						// Doubtful result: two more reads must both match
						r_next.retry = `RETRY_READS;
						r_next.req = 1'b1;
					end
					else if (cyc.rdata != expect_byte)
					begin
						r_next.rsp_err = 1'b1;
						r_next.st = flash_host_pkg::S_RESPOND;
					end
					else if (r_reg.retry > 2'h1)
					begin
						r_next.retry = r_reg.retry - 2'h1;
						r_next.req = 1'b1;
					end
					else
					begin
						r_next.st = flash_host_pkg::S_RESPOND;
					end
				end
			end
			flash_host_pkg::S_READ:
			begin
				if (cyc.done)
				begin
					r_next.rsp_data = cyc.rdata;
					r_next.st = flash_host_pkg::S_RESPOND;
				end
			end
			flash_host_pkg::S_RESPOND:
			begin
				r_next.rsp_valid = 1'b1;
				r_next.ready = 1'b1;
				r_next.st = flash_host_pkg::S_IDLE;
			end
			default:
			begin
				r_next.st = flash_host_pkg::S_IDLE;
				r_next.ready = 1'b1;
			end
		endcase
	end

	// State register
	always_ff @(posedge CLK)
	begin
		if (SRST)
		begin
			r_reg <= '{st: flash_host_pkg::S_IDLE, after: flash_host_pkg::S_IDLE,
				op: flash_host_pkg::OP_READ, step: 3'h0, addr: 19'h00000, data: 8'h00,
				cnt: 11'h000, first: 1'b0, tog: 1'b0, retry: 2'h0, req: 1'b0, wr: 1'b0,
				caddr: 19'h00000, cdata: 8'h00, ready: 1'b1, rsp_valid: 1'b0,
				rsp_data: 8'h00, rsp_err: 1'b0};
		end
		else
		begin
			r_reg <= r_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Cycle engine and outputs

	assign cyc.req = r_reg.req;
	assign cyc.wr = r_reg.wr;
	assign cyc.addr = r_reg.caddr;
	assign cyc.wdata = r_reg.cdata;

	// Pin timing lives in the engine
	flash_bus_cycle u_cycle
	(
		.clk(CLK),
		.srst(SRST),
		.cyc(cyc.engine),
		.addr(F_ADDR),
		.dq_o(F_DQ_O),
		.dq_oe_n(F_DQ_OE_N),
		.dq_i(F_DQ_I),
		.ce_n(F_CE_N),
		.oe_n(F_OE_N),
		.we_n(F_WE_N)
	);

	assign CMD_READY = r_reg.ready;
	assign RSP_VALID = r_reg.rsp_valid;
	assign RSP_DATA = r_reg.rsp_data;
	assign RSP_ERR = r_reg.rsp_err;
endmodule

/* flash_host_sva.sv */
// Checker of the flash host pin and answer timing
`timescale 1ns/1ps
module flash_host_sva
(
	// Clock and reset
	input wire logic CLK,
	input wire logic SRST,
	// Command and answer
	input wire logic CMD_VALID,
	input wire logic [2:0] CMD_OP,
	input wire logic CMD_READY,
	input wire logic RSP_VALID,
	// Flash pins
	input wire logic [18:0] F_ADDR,
	input wire logic [7:0] F_DQ_O,
	input wire logic F_DQ_OE_N,
	input wire logic F_CE_N,
	input wire logic F_OE_N,
	input wire logic F_WE_N
);
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (SRST);
	////////////////////////////////////////////////////////////////////////////////
	// Write strobe only inside a selected cycle with outputs quiet
	property p_we_gate;
		!F_WE_N |-> !F_CE_N && F_OE_N && !F_DQ_OE_N;
	endproperty
	a_we_gate: assert property (p_we_gate)
		else $error("write strobe outside a write cycle");
	// Host never drives while the flash drives
	property p_oe_float;
		!F_OE_N |-> F_DQ_OE_N && F_WE_N;
	endproperty
	a_oe_float: assert property (p_oe_float)
		else $error("bus contention during read");
	// Strobe wide enough to pass the glitch filter
	property p_we_width;
		$fell(F_WE_N) |=> !F_WE_N;
	endproperty
	a_we_width: assert property (p_we_width)
		else $error("write strobe too short");
	// Address frozen while the strobe is low
	property p_addr_hold;
		!F_WE_N |-> $stable(F_ADDR);
	endproperty
	a_addr_hold: assert property (p_addr_hold)
		else $error("address moved under write strobe");
	// Data still driven and unchanged at the strobe rise
	property p_data_hold;
		$rose(F_WE_N) |-> $stable(F_DQ_O) && !F_DQ_OE_N;
	endproperty
	a_data_hold: assert property (p_data_hold)
		else $error("write data released at strobe rise");
	// Select falls before either strobe
	property p_ce_first;
		$fell(F_CE_N) |-> F_WE_N && F_OE_N;
	endproperty
	a_ce_first: assert property (p_ce_first)
		else $error("strobe together with select fall");
	// Plain read answers after the fixed walk
	property p_read_lat;
		CMD_VALID && CMD_READY && CMD_OP == 3'h0 |=> !RSP_VALID [*8] ##[1:2] RSP_VALID;
	endproperty
	a_read_lat: assert property (p_read_lat)
		else $error("read answer late or early");
	// Answer is one pulse and frees the port
	property p_rsp_pulse;
		RSP_VALID |-> CMD_READY ##1 !RSP_VALID;
	endproperty
	a_rsp_pulse: assert property (p_rsp_pulse)
		else $error("answer pulse malformed");
endmodule
bind flash_host flash_host_sva u_flash_host_sva (.CLK(CLK), .SRST(SRST), .CMD_VALID(CMD_VALID),
	.CMD_OP(CMD_OP), .CMD_READY(CMD_READY), .RSP_VALID(RSP_VALID), .F_ADDR(F_ADDR),
	.F_DQ_O(F_DQ_O), .F_DQ_OE_N(F_DQ_OE_N), .F_CE_N(F_CE_N), .F_OE_N(F_OE_N), .F_WE_N(F_WE_N));

/* flash_dev_model.sv */
// Behavioural parallel flash answering the host pins
`timescale 1ns/1ps
module flash_dev_model
#(
	parameter logic [7:0] MAKER_CODE = 8'h3C, // Arbitrary value
	parameter logic [7:0] PART_CODE = 8'h4D // Arbitrary value
)
(
	// Timing base and test controls
	input wire logic clk,
	input wire logic stuck,
	input wire logic [9:0] busy_cyc,
	// Flash pins
	input wire logic [18:0] addr,
	input wire logic [7:0] dq_o,
	output logic [7:0] dq_i,
	input wire logic ce_n,
	input wire logic oe_n,
	input wire logic we_n
);
	logic [7:0] mem [int]; // Absent entry reads erased
	logic [18:0] wa; // Latched write address
	logic [7:0] pd, last, cur; // Program data, last output, array byte
	int st, busy, settle;
	logic idm, er, tog;
	realtime tf;
	function automatic logic [7:0] rd(int a);
		return mem.exists(a) ? mem[a] : 8'hFF;
	endfunction
	initial
	begin
		st = 0;
		busy = 0;
		settle = 0;
		{idm, er, tog} = 3'h0;
		last = 8'h00;
	end
	// Released bus shows the inverse, never a stale value
	assign dq_i = (oe_n || ce_n) ? ~last : last;
	////////////////////////////////////////////////////////////////////////////////
	// Busy time, then 1 us where only the top bit is true
	always @(posedge clk)
	begin
		if (busy > 0 && !stuck)
			busy <= busy - 1;
		settle <= (busy == 1 && !stuck) ? 50 : (settle > 0 ? settle - 1 : 0);
	end
	// Unlock sequencer
	task automatic wr(logic [18:0] a, logic [7:0] d);
		logic u;
		u = (a == 19'h05555);
		if (st != 6 && d == 8'hF0)
		begin
			idm = 1'b0;
			st = 0;
		end
		else case (st)
			0, 3: st = (u && d == 8'hAA) ? st + 1 : 0;
			1, 4: st = (a == 19'h02AAA && d == 8'h55) ? st + 1 : 0;
			2:
			begin
				idm = idm | (u && d == 8'h90);
				st = !u ? 0 : (d == 8'h80 ? 3 : (d == 8'hA0 ? 6 : 0));
			end
			6:
			begin
				pd = d;
				mem[a] = rd(a) & d;
				er = 1'b0;
				busy = int'(busy_cyc);
				st = 0;
			end
			default:
			begin
				if (d == 8'h30)
					for (int i = 0; i < 4096; i++)
						mem.delete({a[18:12], 12'h000} + i);
				if (d == 8'h10 && u)
					mem.delete();
				if (d == 8'h30 || (d == 8'h10 && u))
					{er, busy} = {1'b1, int'(busy_cyc)};
				st = 0;
			end
		endcase
	endtask
	// Address at strobe fall, data at rise
	always @(negedge we_n)
	begin
		tf = $realtime;
		if (!ce_n)
			wa = addr;
	end
	always @(posedge we_n)
		if (!ce_n && oe_n && busy == 0 && $realtime - tf >= 5.0)
			wr(wa, dq_o);
	// Output fixed at output-enable fall
	always @(negedge oe_n)
		if (!ce_n)
		begin
			tog = tog ^ (busy > 0);
			if (busy > 0)
				last = {er ? 1'b0 : ~pd[7], tog, ~pd[5:0]};
			else if (idm && addr < 19'h2)
				last = addr[0] ? PART_CODE : MAKER_CODE;
			else
			begin
				cur = rd(addr);
				last = settle > 0 ? {cur[7], ~cur[6:0]} : cur;
			end
		end
endmodule

/* flash_host_tb_top.sv */
// Self-checking bench of the flash host against a behavioural flash
`timescale 1ns/1ps
module flash_host_tb_top;
	localparam logic [7:0] MAKER = 8'h3C; // Arbitrary value
	localparam logic [7:0] PART = 8'h4D; // Arbitrary value
	logic clk, srst, cmd_valid, cmd_ready, rsp_valid, rsp_err, f_dq_oe_n, f_ce_n, f_oe_n, f_we_n;
	logic stuck;
	logic [2:0] cmd_op;
	logic [18:0] cmd_addr, f_addr;
	logic [7:0] cmd_data, rsp_data, f_dq_o, f_dq_i;
	logic [9:0] busy_cyc;
	int mismatches, total_checks, cycles, seed;
	logic [7:0] em [int]; // Reference array
	logic [18:0] pa [4]; // Programmed places, one per block
	flash_host u_flash_host (.CLK(clk), .SRST(srst), .CMD_VALID(cmd_valid), .CMD_OP(cmd_op),
		.CMD_ADDR(cmd_addr), .CMD_DATA(cmd_data), .CMD_READY(cmd_ready), .RSP_VALID(rsp_valid),
		.RSP_DATA(rsp_data), .RSP_ERR(rsp_err), .F_ADDR(f_addr), .F_DQ_O(f_dq_o),
		.F_DQ_OE_N(f_dq_oe_n), .F_DQ_I(f_dq_i), .F_CE_N(f_ce_n), .F_OE_N(f_oe_n), .F_WE_N(f_we_n));
	flash_dev_model #(.MAKER_CODE(MAKER), .PART_CODE(PART)) u_flash_dev_model (.clk(clk),
		.stuck(stuck), .busy_cyc(busy_cyc), .addr(f_addr), .dq_o(f_dq_o), .dq_i(f_dq_i),
		.ce_n(f_ce_n), .oe_n(f_oe_n), .we_n(f_we_n));
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	function automatic logic [7:0] ev(int a);
		return em.exists(a) ? em[a] : 8'hFF;
	endfunction
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk_data(string n, logic [7:0] e, logic [7:0] g);
		total_checks++;
		if (g !== e)
		begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic chk_flag(string n, logic e, logic g);
		total_checks++;
		if (g !== e)
		begin
			mismatches++;
			$display("mismatch %s expected %b seen %b", n, e, g);
		end
	endtask
	// One command, held for one clock without checking ready, then wait for its answer
	task automatic cmd(logic [2:0] op, logic [18:0] a, logic [7:0] d);
		@(posedge clk);
		#1;
		{cmd_valid, cmd_op, cmd_addr, cmd_data} = {1'b1, op, a, d};
		@(posedge clk);
		#1;
		cmd_valid = 1'b0;
		while (rsp_valid !== 1'b1)
			@(negedge clk);
	endtask
	task automatic rd_chk(logic [18:0] a);
		cmd(3'h0, a, 8'h00);
		chk_data("array", ev(a), rsp_data);
	endtask
	// Hang guard
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			mismatches++;
			wrap_up();
		end
	end
	initial
	begin
		logic [7:0] d;
		{srst, cmd_valid, cmd_op, cmd_addr, cmd_data, stuck} = {1'b1, 32'h0};
		{mismatches, total_checks, cycles, seed, busy_cyc} = {96'h0, 32'd99090, 10'd20};
		repeat (2) @(posedge clk);
		#1;
		srst = 1'b0;
		chk_flag("idle_we", 1'b1, f_we_n);
		// Programs with fast and slow device
		for (int i = 0; i < 4; i++)
		begin
			pa[i] = {7'(i + 1), 12'($random(seed))};
			d = 8'($random(seed));
			busy_cyc = 10'd20 + 10'($unsigned($random(seed)) % 280);
			cmd(3'h1, pa[i], d);
			em[pa[i]] = d;
			chk_flag("prog_err", 1'b0, rsp_err);
			rd_chk(pa[i]);
		end
		// Identification codes, then exit
		cmd(3'h4, 19'h00000, 8'h00);
		cmd(3'h0, 19'h00000, 8'h00);
		chk_data("maker", MAKER, rsp_data);
		cmd(3'h0, 19'h00001, 8'h00);
		chk_data("part", PART, rsp_data);
		cmd(3'h5, 19'h00000, 8'h00);
		rd_chk(19'h00001);
		// Block erase from an inner address
		busy_cyc = 10'd400;
		cmd(3'h2, pa[0] ^ 19'h00ABC, 8'h00);
		chk_flag("sector_err", 1'b0, rsp_err);
		for (int i = 0; i < 4096; i++)
			em.delete({pa[0][18:12], 12'h000} + i);
		rd_chk(pa[0]);
		rd_chk(pa[1]);
		// Device that never finishes
		stuck = 1'b1;
		cmd(3'h1, pa[0], 8'h5A);
		chk_flag("timeout_err", 1'b1, rsp_err);
		em[pa[0]] = 8'h5A;
		@(posedge clk);
		#1;
		stuck = 1'b0;
		repeat (500) @(posedge clk);
		rd_chk(pa[0]);
		// Whole array erase
		busy_cyc = 10'd600;
		cmd(3'h3, 19'h00000, 8'h00);
		chk_flag("chip_err", 1'b0, rsp_err);
		em.delete();
		for (int i = 0; i < 4; i++)
			rd_chk(pa[i]);
		wrap_up();
	end
endmodule
